//--- hw/crf_pkg.sv
package crf_pkg;
  localparam int DATA_W = 16;
  localparam int SEL_W = 4;
  // register space indices
  localparam logic [3:0] REG_IP = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_MCAND = 4'h3;
  localparam logic [3:0] REG_MPLIER = 4'h4;
  localparam logic [3:0] REG_INDEX = 4'h5;
  // port space indices
  localparam logic [3:0] PORT_MDATA = 4'hD;
  localparam logic [3:0] PORT_MADDR = 4'hE;
  localparam logic [3:0] PORT_MCTRL = 4'hF;
  // module control port fields
  localparam int CTRL_GO_BIT = 15;
  localparam int CTRL_DIR_BIT = 14;
  localparam int MOD_ADDR_W = 8;
  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] PORT_RESET = 16'h0000;
  // opcodes (upper nibble of the instruction byte; OP_MULT is matched against the whole byte)
  localparam logic [3:0] OP_LDA = 4'h0;
  localparam logic [3:0] OP_STA = 4'h1;
  localparam logic [3:0] OP_CLR = 4'h2;
  localparam logic [3:0] OP_ADD = 4'h3;
  localparam logic [3:0] OP_SHR = 4'h7;
  localparam logic [3:0] OP_INC = 4'h8;
  localparam logic [3:0] OP_DEC = 4'h9;
  localparam logic [3:0] OP_NOT = 4'hA;
  localparam logic [3:0] OP_BPZ = 4'hB;
  localparam logic [3:0] OP_BNZ = 4'hC;
  localparam logic [3:0] OP_RDP = 4'hD;
  localparam logic [3:0] OP_WRP = 4'hE;
  localparam logic [7:0] OP_MULT = 8'hF3;
  // timing
  localparam int MULT_CYCLES = 16;
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_MULT,
    ST_XFER
  } crf_state_e;
endpackage

//--- hw/crf_multiply.sv
`timescale 1ns/1ns
// shift-add multiplier, one multiplier bit per cycle
module crf_multiply #(
  parameter int WIDTH = crf_pkg::DATA_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_mcand,
  input wire logic [WIDTH-1:0] i_mplier,
  output logic o_done,
  output logic [2*WIDTH-1:0] o_product
);
  import crf_pkg::*;

  if (WIDTH != MULT_CYCLES) begin : g_chk
    $error("crf_multiply: width must equal the multiply cycle count");
  end

  logic [WIDTH-1:0] mcand_ff;
  logic [WIDTH-1:0] mplier_ff;
  logic [2*WIDTH-1:0] acc_ff;
  logic [$clog2(WIDTH+1)-1:0] cnt_ff;
  logic busy_ff;
  logic [2*WIDTH-1:0] nxt_acc;

  always_comb begin
    nxt_acc = acc_ff;
    if (mplier_ff[0]) begin
      nxt_acc = acc_ff + ({{WIDTH{1'b0}}, mcand_ff} << (WIDTH - cnt_ff));
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mcand_ff <= '0;
      mplier_ff <= '0;
      acc_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      o_done <= 1'b0;
      o_product <= '0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      if (i_start && !busy_ff) begin
        mcand_ff <= i_mcand;
        mplier_ff <= i_mplier;
        acc_ff <= '0;
        cnt_ff <= ($clog2(WIDTH+1))'(WIDTH);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        acc_ff <= nxt_acc;
        mplier_ff <= mplier_ff >> 1;
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == 1) begin
          busy_ff <= 1'b0;
          o_done <= 1'b1;
          o_product <= nxt_acc;
        end
      end
    end
  end
endmodule

//--- hw/crf_module_access.sv
`timescale 1ns/1ns
// one indirect transfer to a functional module register
module crf_module_access #(
  parameter int ADDR_W = crf_pkg::MOD_ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic i_read,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_mod_req,
  output logic o_mod_read,
  output logic [ADDR_W-1:0] o_mod_addr,
  output logic [15:0] o_mod_wdata,
  input wire logic i_mod_ack,
  input wire logic [15:0] i_mod_rdata
);
  import crf_pkg::*;

  if (ADDR_W < 1 || ADDR_W > DATA_W) begin : g_chk
    $error("crf_module_access: address width out of range");
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mod_req <= 1'b0;
      o_mod_read <= 1'b0;
      o_mod_addr <= '0;
      o_mod_wdata <= '0;
      o_done <= 1'b0;
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      if (o_mod_req && i_mod_ack) begin
        o_mod_req <= 1'b0;
        o_done <= 1'b1;
        o_rdata <= i_mod_rdata;
      end else if (i_start && !o_mod_req) begin
        o_mod_req <= 1'b1;
        o_mod_read <= i_read;
        o_mod_addr <= i_addr;
        o_mod_wdata <= i_wdata;
      end
    end
  end
endmodule

//--- hw/crf_core.sv
`timescale 1ns/1ns
module crf_core (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_instr_valid,
  input wire logic [7:0] i_instr,
  output logic o_instr_ready,
  output logic [crf_pkg::DATA_W-1:0] o_fetch_addr,
  output logic o_mod_req,
  output logic o_mod_read,
  output logic [crf_pkg::MOD_ADDR_W-1:0] o_mod_addr,
  output logic [crf_pkg::DATA_W-1:0] o_mod_wdata,
  input wire logic i_mod_ack,
  input wire logic [crf_pkg::DATA_W-1:0] i_mod_rdata
);
  import crf_pkg::*;

  logic [DATA_W-1:0] regs_ff [16];
  logic [DATA_W-1:0] ports_ff [16];
  crf_state_e state_ff;

  logic [3:0] op;
  logic [3:0] sel;
  logic fire;
  logic [DATA_W-1:0] rx;
  logic [DATA_W-1:0] px;
  logic [DATA_W-1:0] acc;
  logic wr_en;
  logic [DATA_W-1:0] wr_val;
  logic [3:0] wr_idx;
  logic [DATA_W-1:0] nxt_ip;
  logic mult_start;
  logic mult_done;
  logic [2*DATA_W-1:0] mult_prod;
  logic xfer_start;
  logic xfer_done;
  logic [DATA_W-1:0] xfer_rdata;
  logic xfer_read;
  logic [DATA_W-1:0] chk_mcand_ff;
  logic [DATA_W-1:0] chk_mplier_ff;
  logic [4:0] chk_mult_age_ff;

  function automatic logic branch_taken(input logic [3:0] f_op, input logic [DATA_W-1:0] f_index);
    branch_taken = 1'b0;
    if (f_op == OP_BPZ) begin
      branch_taken = !f_index[DATA_W-1];
    end else if (f_op == OP_BNZ) begin
      branch_taken = (f_index != '0);
    end
  endfunction

  assign op = i_instr[7:4];
  assign sel = i_instr[3:0];
  assign acc = regs_ff[REG_ACC];
  assign rx = regs_ff[sel];
  assign px = ports_ff[sel];
  assign o_instr_ready = (state_ff == ST_EXEC);
  assign fire = i_clk_en && i_instr_valid && o_instr_ready;
  assign o_fetch_addr = regs_ff[REG_IP];
  assign xfer_read = acc[CTRL_DIR_BIT];

  // register write decode
  always_comb begin
    wr_en = 1'b0;
    wr_idx = sel;
    wr_val = rx;
    unique case (op)
      OP_LDA: begin
        wr_en = 1'b1;
        wr_idx = REG_ACC;
        wr_val = rx;
      end
      OP_STA: begin
        wr_en = 1'b1;
        wr_val = acc;
      end
      OP_CLR: begin
        wr_en = 1'b1;
        wr_val = '0;
      end
      OP_ADD: begin
        wr_en = 1'b1;
        wr_idx = REG_ACC;
        wr_val = acc + rx;
      end
      OP_SHR: begin
        wr_en = 1'b1;
        wr_val = {rx[DATA_W-1], rx[DATA_W-1:1]};
      end
      OP_INC: begin
        wr_en = 1'b1;
        wr_val = rx + 1'b1;
      end
      OP_DEC: begin
        wr_en = 1'b1;
        wr_val = rx - 1'b1;
      end
      OP_NOT: begin
        wr_en = 1'b1;
        wr_val = ~rx;
      end
      OP_RDP: begin
        wr_en = 1'b1;
        wr_idx = REG_ACC;
        wr_val = px;
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (branch_taken(op, regs_ff[REG_INDEX])) begin
      nxt_ip = regs_ff[REG_IP] + rx;
    end else begin
      nxt_ip = regs_ff[REG_IP] + 1'b1;
    end
  end

  assign mult_start = fire && (i_instr == OP_MULT);
  assign xfer_start = fire && (op == OP_WRP) && (sel == PORT_MCTRL) && acc[CTRL_GO_BIT];

  // register file
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else if (i_clk_en) begin
      if (fire) begin
        regs_ff[REG_IP] <= nxt_ip;
        if (wr_en) begin
          regs_ff[wr_idx] <= wr_val;
        end
      end else if (mult_done) begin
        regs_ff[REG_ACC] <= mult_prod[2*DATA_W-1:DATA_W];
        regs_ff[REG_MPLIER] <= mult_prod[DATA_W-1:0];
      end
    end
  end

  // port file
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        ports_ff[i] <= PORT_RESET;
      end
    end else if (i_clk_en) begin
      if (fire && op == OP_WRP) begin
        ports_ff[sel] <= acc;
      end else if (xfer_done) begin
        ports_ff[PORT_MCTRL][CTRL_GO_BIT] <= 1'b0;
        if (o_mod_read) begin
          ports_ff[PORT_MDATA] <= xfer_rdata;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_EXEC;
    end else if (i_clk_en) begin
      unique case (state_ff)
        ST_EXEC: begin
          if (mult_start) begin
            state_ff <= ST_MULT;
          end else if (xfer_start) begin
            state_ff <= ST_XFER;
          end
        end
        ST_MULT: begin
          if (mult_done) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_XFER: begin
          if (xfer_done) begin
            state_ff <= ST_EXEC;
          end
        end
        default: begin
          state_ff <= ST_EXEC;
        end
      endcase
    end
  end

  // operand copies and enabled-cycle count for the multiply checks
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chk_mcand_ff <= REG_RESET;
      chk_mplier_ff <= REG_RESET;
      chk_mult_age_ff <= '0;
    end else if (i_clk_en) begin
      if (mult_start) begin
        chk_mcand_ff <= regs_ff[REG_MCAND];
        chk_mplier_ff <= regs_ff[REG_MPLIER];
        chk_mult_age_ff <= '0;
      end else if (state_ff == ST_MULT) begin
        chk_mult_age_ff <= chk_mult_age_ff + 5'h01;
      end
    end
  end

  crf_multiply #(
    .WIDTH(DATA_W)
  ) u_mult (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_start(mult_start),
    .i_mcand(regs_ff[REG_MCAND]),
    .i_mplier(regs_ff[REG_MPLIER]),
    .o_done(mult_done),
    .o_product(mult_prod)
  );

  crf_module_access #(
    .ADDR_W(MOD_ADDR_W)
  ) u_access (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_start(xfer_start),
    .i_read(xfer_read),
    .i_addr(ports_ff[PORT_MADDR][MOD_ADDR_W-1:0]),
    .i_wdata(ports_ff[PORT_MDATA]),
    .o_done(xfer_done),
    .o_rdata(xfer_rdata),
    .o_mod_req(o_mod_req),
    .o_mod_read(o_mod_read),
    .o_mod_addr(o_mod_addr),
    .o_mod_wdata(o_mod_wdata),
    .i_mod_ack(i_mod_ack),
    .i_mod_rdata(i_mod_rdata)
  );

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_go_written;
    fire && op == OP_WRP && sel == PORT_MCTRL && acc[CTRL_GO_BIT];
  endsequence

  sequence s_read_ack;
    i_clk_en && o_mod_req && i_mod_ack && o_mod_read;
  endsequence

  a_ip_step: assert property (fire && !wr_en && op != OP_BPZ && op != OP_BNZ |=>
    regs_ff[REG_IP] == $past(regs_ff[REG_IP]) + 16'h0001)
    else $error("pointer did not advance by one");

  a_go_starts: assert property (s_go_written |=> state_ff == ST_XFER ##1 o_mod_req)
    else $error("control write did not start a transfer");

  a_read_loads: assert property (s_read_ack |-> ##2 ports_ff[PORT_MDATA] == $past(i_mod_rdata, 2))
    else $error("module read did not load data port");

  a_write_keeps: assert property (state_ff == ST_XFER && !o_mod_read && o_mod_req |=>
    $stable(ports_ff[PORT_MDATA]))
    else $error("module write changed data port");

  a_addr_kept: assert property (state_ff == ST_XFER |=> $stable(ports_ff[PORT_MADDR]))
    else $error("address port changed during transfer");

  a_addr_low: assert property (o_mod_req |-> o_mod_addr == ports_ff[PORT_MADDR][MOD_ADDR_W-1:0])
    else $error("module address not from low byte");

  a_go_clears: assert property (xfer_done |=> !ports_ff[PORT_MCTRL][CTRL_GO_BIT] && o_instr_ready)
    else $error("go bit not cleared on completion");

  a_stall_exec: assert property (o_mod_req || state_ff == ST_MULT |-> !o_instr_ready)
    else $error("instruction accepted while busy");

  a_mcand_kept: assert property (state_ff == ST_MULT |=> $stable(regs_ff[REG_MCAND]))
    else $error("multiplicand changed by multiply");

  a_mult_result: assert property (mult_done && i_clk_en |=>
    {regs_ff[REG_ACC], regs_ff[REG_MPLIER]} == {{DATA_W{1'b0}}, chk_mcand_ff} * {{DATA_W{1'b0}}, chk_mplier_ff})
    else $error("multiply result wrong");

  a_mult_timing: assert property (mult_done && state_ff == ST_MULT |-> chk_mult_age_ff == 5'(MULT_CYCLES))
    else $error("multiply finished after wrong cycle count");

  a_mplier_low: assert property (mult_done && i_clk_en |=>
    regs_ff[REG_MPLIER] == DATA_W'(chk_mcand_ff * chk_mplier_ff))
    else $error("multiplier register not loaded with low word");

  a_branch_pos: assert property (fire && op == OP_BPZ && !regs_ff[REG_INDEX][DATA_W-1] |=>
    regs_ff[REG_IP] == $past(regs_ff[REG_IP]) + $past(rx))
    else $error("branch on nonnegative index not taken");

  a_branch_zero: assert property (fire && op == OP_BNZ && regs_ff[REG_INDEX] == '0 |=>
    regs_ff[REG_IP] == $past(regs_ff[REG_IP]) + 16'h0001)
    else $error("branch on zero index taken");

  a_branch_nz_taken: assert property (fire && op == OP_BNZ && regs_ff[REG_INDEX] != '0 |=>
    regs_ff[REG_IP] == $past(regs_ff[REG_IP]) + $past(rx))
    else $error("branch on nonzero index not taken");

  a_branch_neg_skip: assert property (fire && op == OP_BPZ && regs_ff[REG_INDEX][DATA_W-1] |=>
    regs_ff[REG_IP] == $past(regs_ff[REG_IP]) + 16'h0001)
    else $error("branch on negative index taken");

  a_acc_store: assert property (fire && op == OP_STA && sel != REG_IP |=>
    regs_ff[$past(sel)] == $past(acc))
    else $error("accumulator not stored to register");

  a_port_store: assert property (fire && op == OP_WRP |=>
    ports_ff[$past(sel)] == $past(acc))
    else $error("accumulator not stored to port");

  a_port_read: assert property (fire && op == OP_RDP |=>
    regs_ff[REG_ACC] == $past(px))
    else $error("port not read into accumulator");

  a_freeze_holds: assert property (!i_clk_en |=>
    $stable(regs_ff[REG_IP]) && $stable(state_ff) && $stable(o_mod_req))
    else $error("state changed while clock enable low");
endmodule

//--- testbench/crf_mod_model.sv
`timescale 1ns/1ns
// functional-module side: register array with a settable ack latency
module crf_mod_model (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_mod_req,
  input wire logic i_mod_read,
  input wire logic [7:0] i_mod_addr,
  input wire logic [15:0] i_mod_wdata,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_cnt;
  logic [7:0] last_addr;
  logic last_read;
  // read data toggles outside the ack cycle so stale values never look valid
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h5A5A;
      wait_cnt <= 4'h0;
      last_addr <= 8'hFF;
      last_read <= 1'b0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (i_mod_req && wait_cnt == i_delay) begin
      o_ack <= 1'b1;
      wait_cnt <= 4'h0;
      last_addr <= i_mod_addr;
      last_read <= i_mod_read;
      if (i_mod_read) begin
        o_rdata <= mem[i_mod_addr];
      end else begin
        mem[i_mod_addr] <= i_mod_wdata;
        o_rdata <= ~o_rdata;
      end
    end else begin
      wait_cnt <= i_mod_req ? wait_cnt + 4'h1 : 4'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

//--- testbench/cpu_regfile_module_port_tb.sv
`timescale 1ns/1ns
module cpu_regfile_module_port_tb;
  import crf_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [7:0] i_instr = 8'h00;
  logic [3:0] delay = 4'h0;
  logic o_instr_ready;
  logic o_mod_req;
  logic o_mod_read;
  logic i_mod_ack;
  logic [15:0] o_fetch_addr;
  logic [15:0] o_mod_wdata;
  logic [15:0] i_mod_rdata;
  logic [7:0] o_mod_addr;
  logic [15:0] ip_exp = 16'h0000;
  int n_mismatch = 0;
  int num_checks = 0;
  always #50 i_clock = ~i_clock;
  crf_core uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
    .o_fetch_addr(o_fetch_addr), .o_mod_req(o_mod_req), .o_mod_read(o_mod_read),
    .o_mod_addr(o_mod_addr), .o_mod_wdata(o_mod_wdata), .i_mod_ack(i_mod_ack), .i_mod_rdata(i_mod_rdata));
  crf_mod_model mdl (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mod_req(o_mod_req),
    .i_mod_read(o_mod_read), .i_mod_addr(o_mod_addr), .i_mod_wdata(o_mod_wdata),
    .i_delay(delay), .o_ack(i_mod_ack), .o_rdata(i_mod_rdata));
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_instr_ready !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 200) chk("ready_wait", 16'h0001, 16'h0000);
  endtask
  // valid stays up during a stall; the core refuses it until ready
  task automatic ex(input logic [7:0] b, input logic [15:0] d = 16'h0001);
    wait_ready();
    i_instr_valid = 1'b1;
    i_instr = b;
    ip_exp = ip_exp + d;
    @(negedge i_clock);
  endtask
  task automatic fin();
    i_instr_valid = 1'b0;
    @(negedge i_clock);
    wait_ready();
    chk("fetch_addr", ip_exp, o_fetch_addr);
  endtask
  // register x reaches the module side by a module write to address 00
  task automatic show(input logic [3:0] x, input logic [15:0] e);
    ex({OP_LDA, x});
    ex({OP_WRP, PORT_MDATA});
    ex({OP_LDA, 4'hE});
    ex({OP_WRP, PORT_MCTRL});
    fin();
    chk("module_word", e, mdl.mem[0]);
  endtask
  task automatic load(input logic [15:0] v, input logic [3:0] x);
    mdl.mem[0] = v;
    ex({OP_LDA, 4'hF});
    ex({OP_WRP, PORT_MCTRL});
    chk("ready_in_xfer", 16'h0000, {15'h0000, o_instr_ready});
    ex({OP_RDP, PORT_MDATA});
    ex({OP_STA, x});
  endtask
  task automatic t_reset();
    chk("rst_fetch", 16'h0000, o_fetch_addr);
    chk("rst_req", 16'h0000, {15'h0000, o_mod_req});
  endtask
  // constants by doubling: 4000 in reg 2, 8000 in reg 14, C000 in reg 15 and port 14
  task automatic t_setup();
    ex({OP_CLR, REG_ACC});
    ex({OP_INC, REG_ACC});
    repeat (14) ex({OP_ADD, REG_ACC});
    ex({OP_STA, 4'h2});
    ex({OP_ADD, REG_ACC});
    ex({OP_STA, 4'hE});
    ex({OP_ADD, 4'h2});
    ex({OP_STA, 4'hF});
    ex({OP_WRP, PORT_MADDR});
    show(4'hE, 16'h8000);
    show(4'h2, 16'h4000);
  endtask
  task automatic t_nogo();
    ex({OP_LDA, 4'h2});
    ex({OP_WRP, PORT_MCTRL});
    fin();
    repeat (6) begin
      @(negedge i_clock);
      chk("idle_req", 16'h0000, {15'h0000, o_mod_req});
    end
  endtask
  task automatic t_xfer();
    delay = 4'h4;
    load(16'h1234, REG_MCAND);
    chk("dir_read", 16'h0001, {15'h0000, mdl.last_read});
    chk("mod_addr", 16'h0000, {8'h00, mdl.last_addr});
    show(REG_MCAND, 16'h1234);
    chk("dir_write", 16'h0000, {15'h0000, mdl.last_read});
    mdl.mem[0] = 16'h0000;
    ex({OP_LDA, 4'hE});
    ex({OP_WRP, PORT_MCTRL});
    fin();
    chk("data_kept", 16'h1234, mdl.mem[0]);
    ex({OP_RDP, PORT_MCTRL});
    ex({OP_STA, 4'h9});
    ex({OP_RDP, PORT_MADDR});
    ex({OP_STA, 4'h8});
    show(4'h9, 16'h0000);
    show(4'h8, 16'hC000);
    delay = 4'h0;
  endtask
  task automatic t_mult();
    load(16'hFFFF, REG_MCAND);
    load(16'h0003, REG_MPLIER);
    ex({OP_CLR, REG_ACC});
    ex(OP_MULT);
    show(REG_ACC, 16'h0002);
    show(REG_MPLIER, 16'hFFFD);
    show(REG_MCAND, 16'hFFFF);
  endtask
  task automatic t_branch();
    load(16'h8000, REG_INDEX);
    load(16'h0005, 4'h6);
    ex({OP_BPZ, 4'h6}, 16'h0001);
    ex({OP_BNZ, 4'h6}, 16'h0005);
    fin();
    load(16'h0000, REG_INDEX);
    ex({OP_BPZ, 4'h6}, 16'h0005);
    ex({OP_BNZ, 4'h6}, 16'h0001);
    fin();
  endtask
  task automatic t_store();
    load(16'hA55A, 4'h7);
    ex({OP_LDA, 4'h7});
    ex({OP_WRP, 4'h5});
    ex({OP_CLR, REG_ACC});
    ex({OP_RDP, 4'h5});
    ex({OP_STA, 4'hA});
    show(4'hA, 16'hA55A);
    show(4'hF, 16'hC000);
  endtask
  // an instruction offered while the enable is low must wait for it
  task automatic t_freeze();
    wait_ready();
    i_clk_en = 1'b0;
    i_instr_valid = 1'b1;
    i_instr = {OP_INC, 4'h2};
    repeat (4) @(negedge i_clock);
    chk("frozen_fetch", ip_exp, o_fetch_addr);
    i_clk_en = 1'b1;
    ip_exp = ip_exp + 16'h0001;
    @(negedge i_clock);
    fin();
    show(4'h2, 16'h4001);
  endtask
  initial begin
    repeat (12) @(negedge i_clock);
    i_sys_rst = 1'b0;
    t_reset();
    t_setup();
    t_nogo();
    t_xfer();
    t_mult();
    t_branch();
    t_store();
    t_freeze();
    wrap_up();
  end
  initial begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
